// *** logic/cpf_core.sv ***
module cpf_core
    import cpf_pkg::*;
#(
    parameter int STACK_LEVELS = STACK_DEPTH
) (
    input wire logic i_core_clk,
    input wire logic i_nrst,
    input wire logic i_ce,
    input wire logic [INSN_W-1:0] i_pm_data,
    input wire logic [7:0] i_io_rdata,
    input wire logic i_irq_req,
    input wire logic [cpf_pkg::PC_W-1:0] i_irq_vector,
    output logic [cpf_pkg::PC_W-1:0] o_pm_addr,
    output logic [cpf_pkg::IO_ADDR_W-1:0] o_io_addr,
    output logic [7:0] o_io_wdata,
    output logic o_io_we,
    output logic o_io_re,
    output logic o_irq_ack,
    output logic [7:0] o_cpu_status_flags
);
    import cpf_pkg::*;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic insn_is(input logic [15:0] w, input logic [15:0] p,
                                     input logic [15:0] m);
        return (w & m) == p;
    endfunction

    function automatic logic [7:0] set_bit(input logic [7:0] v, input logic [2:0] b,
                                           input logic val);
        logic [7:0] r;
        r = v;
        r[b] = val;
        return r;
    endfunction

    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [PC_W-1:0] pc_reg;
    logic [INSN_W-1:0] ir_reg;
    logic ir_valid_reg;
    logic [7:0] rf_reg [RF_DEPTH];
    logic [7:0] sf_reg;
    cpf_state_t state_reg;
    logic [IO_ADDR_W-1:0] io_addr_reg;
    logic [7:0] io_wdata_reg;
    logic io_we_reg;
    logic io_re_reg;
    logic irq_ack_reg;

    // ----------------------------------------
    // decode of the instruction in execution
    // ----------------------------------------
    logic [RF_IDX_W-1:0] d_idx;
    logic [RF_IDX_W-1:0] r_idx;
    logic [RF_IDX_W-1:0] z_idx;
    logic [IO_ADDR_W-1:0] io_dir_addr;
    logic [4:0] io_bit_addr;
    logic [2:0] bit_sel;
    logic [PC_W-1:0] rel_target;
    logic [7:0] op_d;
    logic [7:0] op_r;

    assign d_idx = ir_reg[8:4];
    assign r_idx = {ir_reg[9], ir_reg[3:0]};
    assign z_idx = rf_reg[ZPTR_IDX][RF_IDX_W-1:0];
    assign io_dir_addr = {ir_reg[10:9], ir_reg[3:0]};
    assign io_bit_addr = ir_reg[7:3];
    assign bit_sel = ir_reg[2:0];
    // pc already points one past the executing word, so pc + k is pc_insn + k + 1
    assign rel_target = pc_reg + ir_reg[PC_W-1:0];
    assign op_d = rf_reg[d_idx];
    assign op_r = rf_reg[r_idx];

    logic is_add, is_adc, is_sub, is_and, is_eor, is_or, is_mov;
    logic is_in, is_out, is_sbi, is_cbi, is_skip_if_io_bit_one, is_skip_if_io_bit_zero;
    logic is_rjmp, is_relative_call, is_ret, is_irq_return, is_bld, is_bst, is_ldz, is_stz;

    always_comb begin
        is_add = insn_is(ir_reg, P_ADD, M_2REG);
        is_adc = insn_is(ir_reg, P_ADC, M_2REG);
        is_sub = insn_is(ir_reg, P_SUB, M_2REG);
        is_and = insn_is(ir_reg, P_AND, M_2REG);
        is_eor = insn_is(ir_reg, P_EOR, M_2REG);
        is_or = insn_is(ir_reg, P_OR, M_2REG);
        is_mov = insn_is(ir_reg, P_MOV, M_2REG);
        is_in = insn_is(ir_reg, P_IN, M_IO);
        is_out = insn_is(ir_reg, P_OUT, M_IO);
        is_sbi = insn_is(ir_reg, P_IO_BIT_SET, M_IOBIT);
        is_cbi = insn_is(ir_reg, P_IO_BIT_CLEAR, M_IOBIT);
        is_skip_if_io_bit_one = insn_is(ir_reg, P_SKIP_IO_ONE, M_IOBIT);
        is_skip_if_io_bit_zero = insn_is(ir_reg, P_SKIP_IO_ZERO, M_IOBIT);
        is_rjmp = insn_is(ir_reg, P_REL_JUMP, M_REL);
        is_relative_call = insn_is(ir_reg, P_REL_CALL, M_REL);
        is_ret = insn_is(ir_reg, P_SUB_RETURN, M_FULL);
        is_irq_return = insn_is(ir_reg, P_IRQ_RETURN, M_FULL);
        is_bld = insn_is(ir_reg, P_BIT_LOAD, M_BIT);
        is_bst = insn_is(ir_reg, P_BIT_STORE, M_BIT);
        is_ldz = insn_is(ir_reg, P_LOAD_IND, M_IND);
        is_stz = insn_is(ir_reg, P_STORE_IND, M_IND);
    end

    // ----------------------------------------
    // execute: register writes, flags, flow
    // ----------------------------------------
    logic irq_take;
    logic exec_now;
    logic io_in_sf;
    logic io_out_sf;
    logic io_stall;
    logic [8:0] sum9;
    logic [7:0] res;
    logic rf_we;
    logic [RF_IDX_W-1:0] rf_wa;
    logic [7:0] rf_wd;
    logic [7:0] sf_next;
    logic flow_jump;
    logic [PC_W-1:0] flow_target;
    logic do_push;
    logic do_pop;
    logic [PC_W-1:0] push_addr;
    logic [PC_W-1:0] stack_top;
    logic skip_next;

    assign exec_now = (state_reg == CPF_EXEC) && ir_valid_reg && !irq_take;
    assign io_in_sf = is_in && (io_dir_addr == CPU_STATUS_FLAGS_ADDR);
    assign io_out_sf = is_out && (io_dir_addr == CPU_STATUS_FLAGS_ADDR);
    // bus reads and read-modify-writes take a second cycle; status flags do not
    assign io_stall = exec_now && ((is_in && !io_in_sf) || is_sbi || is_cbi || is_skip_if_io_bit_one
                      || is_skip_if_io_bit_zero);

    always_comb begin
        irq_take = (state_reg == CPF_EXEC) && sf_reg[SF_I] && i_irq_req;
        rf_we = 1'b0;
        rf_wa = d_idx;
        rf_wd = 8'h00;
        sf_next = sf_reg;
        flow_jump = 1'b0;
        flow_target = pc_reg;
        do_push = 1'b0;
        do_pop = 1'b0;
        push_addr = pc_reg;
        skip_next = 1'b0;
        sum9 = 9'h000;
        res = 8'h00;
        if (irq_take) begin
            // the word in execution is abandoned and resumed on return
            push_addr = ir_valid_reg ? pc_reg - 9'h001 : pc_reg;
            do_push = 1'b1;
            flow_jump = 1'b1;
            flow_target = i_irq_vector;
            sf_next[SF_I] = 1'b0;
        end else if (state_reg == CPF_IO_WAIT) begin
            if (is_in) begin
                rf_we = 1'b1;
                rf_wd = i_io_rdata;
            end
            if ((is_skip_if_io_bit_one && i_io_rdata[bit_sel]) || (is_skip_if_io_bit_zero && !i_io_rdata[bit_sel])) begin
                skip_next = 1'b1;
            end
        end else if (exec_now) begin
            if (is_add || is_adc) begin
                sum9 = {1'b0, op_d} + {1'b0, op_r} + {8'h00, is_adc & sf_reg[SF_C]};
                res = sum9[7:0];
                sf_next[SF_C] = sum9[8];
                sf_next[SF_H] = (op_d[3] & op_r[3]) | (op_r[3] & ~res[3])
                                | (~res[3] & op_d[3]);
                sf_next[SF_V] = (op_d[7] & op_r[7] & ~res[7])
                                | (~op_d[7] & ~op_r[7] & res[7]);
            end else if (is_sub) begin
                sum9 = {1'b0, op_d} - {1'b0, op_r};
                res = sum9[7:0];
                sf_next[SF_C] = (~op_d[7] & op_r[7]) | (op_r[7] & res[7])
                                | (res[7] & ~op_d[7]);
                sf_next[SF_H] = (~op_d[3] & op_r[3]) | (op_r[3] & res[3])
                                | (res[3] & ~op_d[3]);
                sf_next[SF_V] = (op_d[7] & ~op_r[7] & ~res[7])
                                | (~op_d[7] & op_r[7] & res[7]);
            end else if (is_and || is_eor || is_or) begin
                res = is_and ? (op_d & op_r) : (is_or ? (op_d | op_r) : (op_d ^ op_r));
                sf_next[SF_V] = 1'b0;
            end
            if (is_add || is_adc || is_sub || is_and || is_eor || is_or) begin
                rf_we = 1'b1;
                rf_wd = res;
                sf_next[SF_N] = res[7];
                sf_next[SF_Z] = (res == 8'h00);
                sf_next[SF_S] = res[7] ^ sf_next[SF_V];
            end else if (is_mov) begin
                rf_we = 1'b1;
                rf_wd = op_r;
            end else if (is_in && io_in_sf) begin
                rf_we = 1'b1;
                rf_wd = sf_reg;
            end else if (io_out_sf) begin
                sf_next = op_d;
            end else if (is_bst) begin
                sf_next[SF_T] = op_d[bit_sel];
            end else if (is_bld) begin
                rf_we = 1'b1;
                rf_wd = set_bit(op_d, bit_sel, sf_reg[SF_T]);
            end else if (is_ldz) begin
                rf_we = 1'b1;
                rf_wd = rf_reg[z_idx];
            end else if (is_stz) begin
                rf_we = 1'b1;
                rf_wa = z_idx;
                rf_wd = op_d;
            end else if (is_rjmp || is_relative_call) begin
                flow_jump = 1'b1;
                flow_target = rel_target;
                do_push = is_relative_call;
            end else if (is_ret || is_irq_return) begin
                flow_jump = 1'b1;
                flow_target = stack_top;
                do_pop = 1'b1;
                if (is_irq_return) begin
                    sf_next[SF_I] = 1'b1;
                end
            end
        end
    end

    cpf_ret_stack #(
        .DEPTH(STACK_LEVELS),
        .WIDTH(PC_W)
    ) u_ret_stack (
        .i_core_clk(i_core_clk),
        .i_nrst(i_nrst),
        .i_ce(i_ce),
        .i_push(do_push),
        .i_pop(do_pop),
        .i_ret_addr(push_addr),
        .o_top(stack_top)
    );

    // ----------------------------------------
    // fetch and sequencing
    // ----------------------------------------
    // the core runs on i_core_clk as delivered; nothing divides it
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            pc_reg <= '0;
            ir_reg <= '0;
            ir_valid_reg <= 1'b0;
            state_reg <= CPF_EXEC;
        end else if (i_ce) begin
            if (io_stall) begin
                state_reg <= CPF_IO_WAIT;
            end else begin
                state_reg <= CPF_EXEC;
                if (flow_jump) begin
                    pc_reg <= flow_target;
                    ir_valid_reg <= 1'b0;
                end else begin
                    pc_reg <= pc_reg + 9'h001;
                    ir_reg <= i_pm_data;
                    ir_valid_reg <= !skip_next;
                end
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            for (int i = 0; i < RF_DEPTH; i++) begin
                rf_reg[i] <= 8'h00;
            end
        end else if (i_ce && rf_we) begin
            rf_reg[rf_wa] <= rf_wd;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            sf_reg <= CPU_STATUS_FLAGS_RST;
        end else if (i_ce) begin
            sf_reg <= sf_next;
        end
    end

    // ----------------------------------------
    // I/O bus strobes
    // ----------------------------------------
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            io_addr_reg <= '0;
            io_wdata_reg <= 8'h00;
            io_we_reg <= 1'b0;
            io_re_reg <= 1'b0;
        end else if (i_ce) begin
            io_we_reg <= 1'b0;
            io_re_reg <= 1'b0;
            if (io_stall) begin
                io_re_reg <= 1'b1;
                io_addr_reg <= is_in ? io_dir_addr : {1'b0, io_bit_addr};
            end else if (exec_now && is_out && !io_out_sf) begin
                io_we_reg <= 1'b1;
                io_addr_reg <= io_dir_addr;
                io_wdata_reg <= op_d;
            end else if (state_reg == CPF_IO_WAIT && !irq_take && (is_sbi || is_cbi)) begin
                io_we_reg <= 1'b1;
                io_wdata_reg <= set_bit(i_io_rdata, bit_sel, is_sbi);
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            irq_ack_reg <= 1'b0;
        end else if (i_ce) begin
            irq_ack_reg <= irq_take;
        end
    end

    assign o_pm_addr = pc_reg;
    assign o_io_addr = io_addr_reg;
    assign o_io_wdata = io_wdata_reg;
    assign o_io_we = io_we_reg;
    assign o_io_re = io_re_reg;
    assign o_irq_ack = irq_ack_reg;
    assign o_cpu_status_flags = sf_reg;
endmodule

// *** logic/cpf_pkg.sv ***
package cpf_pkg;
    // ----------------------------------------
    // sizes
    // ----------------------------------------
    localparam int PC_W = 9;
    localparam int PM_WORDS = 512;
    localparam int INSN_W = 16;
    localparam int IO_ADDR_W = 6;
    localparam int RF_DEPTH = 32;
    localparam int RF_IDX_W = 5;
    localparam int STACK_DEPTH = 3;
    localparam logic [4:0] ZPTR_IDX = 5'h1e;

    // ----------------------------------------
    // status flag register and its bit positions
    // ----------------------------------------
    localparam logic [5:0] CPU_STATUS_FLAGS_ADDR = 6'h3f;
    localparam logic [7:0] CPU_STATUS_FLAGS_RST = 8'h00;
    localparam int SF_I = 7;
    localparam int SF_T = 6;
    localparam int SF_H = 5;
    localparam int SF_S = 4;
    localparam int SF_V = 3;
    localparam int SF_N = 2;
    localparam int SF_Z = 1;
    localparam int SF_C = 0;

    // ----------------------------------------
    // instruction encodings: pattern and mask
    // ----------------------------------------
    localparam logic [15:0] M_2REG = 16'hfc00;
    localparam logic [15:0] P_ADD = 16'h0c00;
    localparam logic [15:0] P_ADC = 16'h1c00;
    localparam logic [15:0] P_SUB = 16'h1800;
    localparam logic [15:0] P_AND = 16'h2000;
    localparam logic [15:0] P_EOR = 16'h2400;
    localparam logic [15:0] P_OR = 16'h2800;
    localparam logic [15:0] P_MOV = 16'h2c00;
    localparam logic [15:0] M_IO = 16'hf800;
    localparam logic [15:0] P_IN = 16'hb000;
    localparam logic [15:0] P_OUT = 16'hb800;
    localparam logic [15:0] M_IOBIT = 16'hff00;
    localparam logic [15:0] P_IO_BIT_CLEAR = 16'h9800;
    localparam logic [15:0] P_SKIP_IO_ZERO = 16'h9900;
    localparam logic [15:0] P_IO_BIT_SET = 16'h9a00;
    localparam logic [15:0] P_SKIP_IO_ONE = 16'h9b00;
    localparam logic [15:0] M_REL = 16'hf000;
    localparam logic [15:0] P_REL_JUMP = 16'hc000;
    localparam logic [15:0] P_REL_CALL = 16'hd000;
    localparam logic [15:0] M_FULL = 16'hffff;
    localparam logic [15:0] P_SUB_RETURN = 16'h9508;
    localparam logic [15:0] P_IRQ_RETURN = 16'h9518;
    localparam logic [15:0] M_BIT = 16'hfe08;
    localparam logic [15:0] P_BIT_LOAD = 16'hf800;
    localparam logic [15:0] P_BIT_STORE = 16'hfa00;
    localparam logic [15:0] M_IND = 16'hfe0f;
    localparam logic [15:0] P_LOAD_IND = 16'h8000;
    localparam logic [15:0] P_STORE_IND = 16'h8200;

    // ----------------------------------------
    // sequencer states
    // ----------------------------------------
    typedef enum logic [0:0] {
        CPF_EXEC = 1'b0,
        CPF_IO_WAIT = 1'b1
    } cpf_state_t;
endpackage

// *** logic/cpf_ret_stack.sv ***
module cpf_ret_stack
    import cpf_pkg::*;
#(
    parameter int DEPTH = STACK_DEPTH,
    parameter int WIDTH = PC_W
) (
    input wire logic i_core_clk,
    input wire logic i_nrst,
    input wire logic i_ce,
    input wire logic i_push,
    input wire logic i_pop,
    input wire logic [WIDTH-1:0] i_ret_addr,
    output logic [WIDTH-1:0] o_top
);
    logic [WIDTH-1:0] entry_reg [DEPTH];

    // the deepest entry simply falls off on push: no overflow flag exists
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            for (int i = 0; i < DEPTH; i++) begin
                entry_reg[i] <= '0;
            end
        end else if (i_ce) begin
            if (i_push) begin
                entry_reg[0] <= i_ret_addr;
                for (int i = 1; i < DEPTH; i++) begin
                    entry_reg[i] <= entry_reg[i-1];
                end
            end else if (i_pop) begin
                for (int i = 0; i < DEPTH - 1; i++) begin
                    entry_reg[i] <= entry_reg[i+1];
                end
            end
        end
    end

    assign o_top = entry_reg[0];
endmodule

// *** tb/cpf_core_assertions.sv ***
module cpf_assertions
    import cpf_pkg::*;
#(
    parameter int STACK_LEVELS = cpf_pkg::STACK_DEPTH
) (
    input wire logic i_core_clk,
    input wire logic i_nrst,
    input wire logic i_ce,
    input wire logic [cpf_pkg::INSN_W-1:0] i_pm_data,
    input wire logic [7:0] i_io_rdata,
    input wire logic i_irq_req,
    input wire logic [cpf_pkg::PC_W-1:0] i_irq_vector,
    input wire logic [cpf_pkg::PC_W-1:0] o_pm_addr,
    input wire logic [cpf_pkg::IO_ADDR_W-1:0] o_io_addr,
    input wire logic [7:0] o_io_wdata,
    input wire logic o_io_we,
    input wire logic o_io_re,
    input wire logic o_irq_ack,
    input wire logic [7:0] o_cpu_status_flags
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking @(posedge i_core_clk);
    endclocking
    default disable iff (!i_nrst);

    // ----------------------------------------
    // bit access sequences
    // ----------------------------------------
    sequence s_bit_read;
        o_io_re && !o_io_addr[5];
    endsequence
    sequence s_bit_write;
        o_io_we && o_io_addr == $past(o_io_addr);
    endsequence

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    AST_CPU_STATUS_FLAGS_OFF_BUS: assert property (
        (o_io_we || o_io_re) |-> o_io_addr != CPU_STATUS_FLAGS_ADDR)
        else $error("status flag location seen on io bus");
    AST_SIGN_XOR: assert property (
        o_cpu_status_flags[SF_S] == (o_cpu_status_flags[SF_N] ^ o_cpu_status_flags[SF_V]))
        else $error("sign flag differs from negative xor overflow");
    AST_IRQ_GATED: assert property (
        $rose(o_irq_ack) |-> $past(o_cpu_status_flags[SF_I]))
        else $error("interrupt taken with global enable clear");
    AST_IRQ_CLEARS_I: assert property (
        o_irq_ack |-> !o_cpu_status_flags[SF_I])
        else $error("global enable not cleared on interrupt entry");
    AST_IRQ_VECTOR: assert property (
        o_irq_ack |-> o_pm_addr == $past(i_irq_vector))
        else $error("interrupt did not vector the fetch address");
    AST_ACK_PULSE: assert property (
        o_irq_ack && i_ce |=> !o_irq_ack [*3])
        else $error("interrupt re-entered with enable clear");
    AST_FETCH_ON: assert property (
        o_irq_ack && i_ce |=> o_pm_addr == PC_W'($past(o_pm_addr) + 1))
        else $error("fetch did not advance after vectoring");
    AST_BIT_RMW: assert property (
        // setting a bit that is already set legally writes the value back unchanged
        s_bit_read ##1 s_bit_write |-> $countones(o_io_wdata ^ $past(i_io_rdata)) <= 1)
        else $error("bit write changed more than one bit");
endmodule

bind cpf_core cpf_assertions #(.STACK_LEVELS(STACK_LEVELS)) u_chk (
    .i_core_clk(i_core_clk),
    .i_nrst(i_nrst),
    .i_ce(i_ce),
    .i_pm_data(i_pm_data),
    .i_io_rdata(i_io_rdata),
    .i_irq_req(i_irq_req),
    .i_irq_vector(i_irq_vector),
    .o_pm_addr(o_pm_addr),
    .o_io_addr(o_io_addr),
    .o_io_wdata(o_io_wdata),
    .o_io_we(o_io_we),
    .o_io_re(o_io_re),
    .o_irq_ack(o_irq_ack),
    .o_cpu_status_flags(o_cpu_status_flags)
);

// *** tb/cpf_mem_model.sv ***
module cpf_mem_model
    import cpf_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic [cpf_pkg::PC_W-1:0] i_pm_addr,
    input wire logic [cpf_pkg::IO_ADDR_W-1:0] i_io_addr,
    input wire logic [7:0] i_io_wdata,
    input wire logic i_io_we,
    input wire logic i_io_re,
    output logic [cpf_pkg::INSN_W-1:0] o_pm_data,
    output logic [7:0] o_io_rdata
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [INSN_W-1:0] pm [PM_WORDS];
    logic [7:0] io [64];

    assign o_pm_data = pm[i_pm_addr];
    // outside a read the lines show the inverse, so a late sample is not hidden
    assign o_io_rdata = i_io_re ? io[i_io_addr] : ~io[i_io_addr];

    always @(posedge i_core_clk) begin
        if (i_io_we) begin
            io[i_io_addr] <= i_io_wdata;
        end
    end
endmodule

// *** tb/tb_cpu_program_flow_and_status.sv ***
module tb_cpu_program_flow_and_status
    import cpf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic i_core_clk;
    logic i_nrst;
    logic i_ce;
    logic i_irq_req;
    logic [INSN_W-1:0] i_pm_data;
    logic [7:0] i_io_rdata;
    logic [PC_W-1:0] o_pm_addr;
    logic [IO_ADDR_W-1:0] o_io_addr;
    logic [7:0] o_io_wdata;
    logic [7:0] o_cpu_status_flags;
    logic o_io_we;
    logic o_io_re;
    logic o_irq_ack;
    logic [13:0] exp_q[$];
    int fails = 0;
    int n_checks = 0;
    int widx = 0;
    int n_ack = 0;

    initial begin
        i_core_clk = 1'b0;
        forever #4 i_core_clk = ~i_core_clk;
    end

    cpf_core u_dut (
        .i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_ce(i_ce), .i_pm_data(i_pm_data),
        .i_io_rdata(i_io_rdata), .i_irq_req(i_irq_req), .i_irq_vector(9'h12c),
        .o_pm_addr(o_pm_addr), .o_io_addr(o_io_addr), .o_io_wdata(o_io_wdata),
        .o_io_we(o_io_we), .o_io_re(o_io_re), .o_irq_ack(o_irq_ack),
        .o_cpu_status_flags(o_cpu_status_flags)
    );

    cpf_mem_model u_mem (
        .i_core_clk(i_core_clk), .i_pm_addr(o_pm_addr), .i_io_addr(o_io_addr),
        .i_io_wdata(o_io_wdata), .i_io_we(o_io_we), .i_io_re(o_io_re),
        .o_pm_data(i_pm_data), .o_io_rdata(i_io_rdata)
    );

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk(input logic ok, input string m);
        n_checks++;
        if (ok !== 1'b1) begin
            fails++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    task automatic put(input int a, input logic [15:0] w);
        u_mem.pm[a] = w;
    endtask
    task automatic ex(input logic [5:0] a, input logic [7:0] d);
        exp_q.push_back({a, d});
    endtask
    function automatic logic [15:0] f_two(input logic [15:0] p, input logic [4:0] d,
                                          input logic [4:0] r);
        return p | {6'h00, r[4], d, r[3:0]};
    endfunction
    function automatic logic [15:0] f_io(input logic [15:0] p, input logic [4:0] r,
                                         input logic [5:0] a);
        return p | {5'h00, a[5:4], r, a[3:0]};
    endfunction
    function automatic logic [15:0] f_bit(input logic [15:0] p, input logic [4:0] a,
                                          input logic [2:0] b);
        return p | {8'h00, a, b};
    endfunction
    function automatic logic [15:0] f_bt(input logic [15:0] p, input logic [4:0] d,
                                         input logic [2:0] b);
        return p | {7'h00, d, 1'b0, b};
    endfunction
    function automatic logic [15:0] f_rel(input logic [15:0] p, input int a, input int t);
        logic [11:0] k;
        k = 12'(t - a - 1);
        return p | {4'h0, k};
    endfunction

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // ----------------------------------------
    // monitors
    // ----------------------------------------
    always @(posedge i_core_clk) begin
        if (i_nrst === 1'b1 && o_io_we === 1'b1) begin
            chk(widx < exp_q.size() && {o_io_addr, o_io_wdata} === exp_q[widx],
                $sformatf("io write %h %h", o_io_addr, o_io_wdata));
            widx++;
        end
        if (o_irq_ack === 1'b1) n_ack++;
    end
    // the requester withdraws as soon as it is acknowledged
    always @(negedge i_core_clk) begin
        if (o_irq_ack === 1'b1) i_irq_req <= 1'b0;
    end

    initial begin
        repeat (3000) @(posedge i_core_clk);
        fails++;
        $display("[FAIL] %0t watchdog expired", $time);
        end_of_test();
    end

    // ----------------------------------------
    // program run
    // ----------------------------------------
    initial begin
        i_nrst = 1'b0;
        i_ce = 1'b1;
        i_irq_req = 1'b0;
        for (int a = 0; a < PM_WORDS; a++) u_mem.pm[a] = 16'hcfff;
        for (int a = 0; a < 64; a++) u_mem.io[a] = 8'h00;
        u_mem.io[1] = 8'h7f;
        u_mem.io[2] = 8'h01;
        u_mem.io[3] = 8'hff;
        u_mem.io[5] = 8'h41;
        u_mem.io[6] = 8'h01;
        u_mem.io[7] = 8'h80;
        put(0, f_io(P_IN, 5'd1, 6'h01));
        put(1, f_io(P_IN, 5'd2, 6'h02));
        put(2, f_two(P_ADD, 5'd1, 5'd2));
        put(3, f_io(P_IN, 5'd3, 6'h3f));
        put(4, f_io(P_OUT, 5'd3, 6'h20));
        put(5, f_io(P_OUT, 5'd1, 6'h21));
        put(6, f_io(P_IN, 5'd4, 6'h03));
        put(7, f_two(P_ADD, 5'd4, 5'd2));
        put(8, f_io(P_IN, 5'd5, 6'h3f));
        put(9, f_io(P_OUT, 5'd5, 6'h22));
        put(10, f_bit(P_IO_BIT_SET, 5'h05, 3'd2));
        put(11, f_bit(P_IO_BIT_CLEAR, 5'h05, 3'd0));
        put(12, f_bit(P_SKIP_IO_ONE, 5'h05, 3'd2));
        put(13, f_io(P_OUT, 5'd1, 6'h23));
        put(14, f_bit(P_SKIP_IO_ZERO, 5'h05, 3'd2));
        put(15, f_io(P_OUT, 5'd4, 6'h24));
        put(16, f_rel(P_REL_CALL, 16, 40));
        put(17, f_io(P_OUT, 5'd1, 6'h2f));
        put(40, f_rel(P_REL_CALL, 40, 50));
        put(41, f_io(P_OUT, 5'd1, 6'h28));
        put(42, f_rel(P_REL_JUMP, 42, 100));
        put(50, f_rel(P_REL_CALL, 50, 60));
        put(51, f_io(P_OUT, 5'd1, 6'h27));
        put(52, P_SUB_RETURN);
        put(60, f_rel(P_REL_CALL, 60, 70));
        put(61, f_io(P_OUT, 5'd1, 6'h26));
        put(62, P_SUB_RETURN);
        put(70, f_io(P_OUT, 5'd1, 6'h25));
        put(71, P_SUB_RETURN);
        put(100, f_rel(P_REL_JUMP, 100, 510));
        put(510, f_rel(P_REL_JUMP, 510, 200));
        put(200, f_bt(P_BIT_STORE, 5'd1, 3'd7));
        put(201, f_bt(P_BIT_LOAD, 5'd6, 3'd3));
        put(202, f_io(P_OUT, 5'd6, 6'h29));
        put(203, f_io(P_IN, ZPTR_IDX, 6'h06));
        put(204, f_bt(P_LOAD_IND, 5'd7, 3'd0));
        put(205, f_io(P_OUT, 5'd7, 6'h2a));
        put(206, f_io(P_IN, 5'd8, 6'h07));
        put(207, f_io(P_OUT, 5'd8, 6'h3f));
        put(208, f_io(P_IN, 5'd10, 6'h3f));
        put(209, f_io(P_OUT, 5'd10, 6'h2c));
        put(210, f_rel(P_REL_JUMP, 210, 210));
        put(300, f_io(P_IN, 5'd9, 6'h3f));
        put(301, f_io(P_OUT, 5'd9, 6'h2b));
        put(302, P_IRQ_RETURN);
        ex(6'h20, 8'h2c);
        ex(6'h21, 8'h80);
        ex(6'h22, 8'h23);
        ex(6'h05, 8'h45);
        ex(6'h05, 8'h44);
        ex(6'h24, 8'h00);
        ex(6'h25, 8'h80);
        ex(6'h26, 8'h80);
        ex(6'h27, 8'h80);
        ex(6'h28, 8'h80);
        ex(6'h29, 8'h08);
        ex(6'h2a, 8'h80);
        ex(6'h2b, 8'h00);
        ex(6'h2c, 8'h80);
        repeat (5) @(negedge i_core_clk);
        i_nrst = 1'b1;
        // raised while the global enable is still clear
        i_irq_req = 1'b1;
        for (int i = 0; i < 1000 && widx < exp_q.size(); i++) @(negedge i_core_clk);
        repeat (20) @(negedge i_core_clk);
        chk(widx == exp_q.size(), "io write count");
        chk(n_ack == 1, "interrupt count");
        // the closing self-jump alternates the fetch address between 210 and 211
        if (o_pm_addr !== 9'd210) @(negedge i_core_clk);
        chk(o_pm_addr === 9'd210, "final fetch address");
        i_ce = 1'b0;
        repeat (4) @(negedge i_core_clk);
        chk(o_pm_addr === 9'd210, "fetch address moved while frozen");
        chk(o_cpu_status_flags === 8'h80, "status flags while frozen");
        i_ce = 1'b1;
        @(negedge i_core_clk);
        chk(o_pm_addr === 9'd211, "fetch did not resume after freeze");
        $display("test program flow done");
        end_of_test();
    end
endmodule
